// file: pkg/pair_timer_pkg.sv
// shared constants for the paired 16/32-bit timer
package pair_timer_pkg;

   // ******************************
   // register word addresses
   // ******************************
   localparam logic [3:0] ADDR_CTRL      = 4'h0;
   localparam logic [3:0] ADDR_CNT_LOW   = 4'h1;
   localparam logic [3:0] ADDR_CNT_HIGH  = 4'h2;
   localparam logic [3:0] ADDR_PER_LOW   = 4'h3;
   localparam logic [3:0] ADDR_PER_HIGH  = 4'h4;
   localparam logic [3:0] ADDR_STATUS    = 4'h5;

   // ******************************
   // control field positions
   // ******************************
   localparam int RUN_BIT      = 15;
   localparam int IDLE_BIT     = 13;
   localparam int ECS_LSB      = 8;
   localparam int GATE_BIT     = 6;
   localparam int PRESC_LSB    = 4;
   localparam int WIDE_BIT     = 3;
   localparam int CS_BIT       = 1;
   localparam logic [15:0] CTRL_MASK = 16'hA37A;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // ******************************
   // status bit positions
   // ******************************
   localparam int ST_LOW_FLAG  = 0;
   localparam int ST_HIGH_FLAG = 1;

   // ******************************
   // reset values and clock source codes
   // ******************************
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [1:0]  SRC_SECONDARY_OSC     = 2'h0;
   localparam logic [1:0]  SRC_UPPER    = 2'h1;
   localparam logic [1:0]  SRC_LOW_POWER_RC_OSC     = 2'h2;
   localparam logic [1:0]  SRC_GENERIC  = 2'h3;
   localparam int          SYNC_STAGES  = 3;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ACK
   } bus_state_e;

endpackage

// file: hw/pin_sync_edge.sv
// three-stage pin synchroniser with agreed rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge
   import pair_timer_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // pin side
   input  wire logic pin,
   // core side
   output logic      level,
   output logic      rise
);
   logic [SYNC_STAGES-1:0] stage;
   logic                   agreed;

   // stage 0 feeds only stage 1; decisions use stages 1 and 2
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage  <= '0;
         agreed <= 1'b0;
      end else begin
         stage <= {stage[SYNC_STAGES-2:0], pin};
         if (stage[1] == stage[2]) begin
            agreed <= stage[2];
         end
      end
   end

   assign level = agreed;
   assign rise  = (stage[1] == stage[2]) && stage[2] && !agreed;
endmodule
`default_nettype wire

// file: hw/prescale_div.sv
// prescaler turning source ticks into count ticks
`timescale 1ns/1ps
`default_nettype none
module prescale_div
   import pair_timer_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // control
   input  wire logic       clear,
   input  wire logic [1:0] ratio,
   input  wire logic       tick_in,
   // output
   output logic            tick_out
);
   logic [7:0] cnt;
   logic [7:0] last;

   always_comb begin
      case (ratio)
         2'h0:    last = 8'h00;
         2'h1:    last = 8'h07;
         2'h2:    last = 8'h3F;
         default: last = 8'hFF;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 8'h00;
      end else if (clear) begin
         cnt <= 8'h00;
      end else if (tick_in) begin
         cnt <= (cnt >= last) ? 8'h00 : cnt + 8'h01;
      end
   end

   assign tick_out = tick_in && !clear && (cnt >= last);
endmodule
`default_nettype wire

// file: hw/pair_timer.sv
// paired 16/32-bit timer with Avalon-MM register slave
//
// Notes on behaviour
// - pair runs as two 16-bit timers or one 32-bit timer/counter
// - control bit 3 joins the pair into one 32-bit timer
// - lower timer is the low word, upper timer the high word
// - upper timer control is ignored in 32-bit operation
// - 32-bit uses lower clock and gate, raises upper interrupt flag
// - 32-bit period: upper period high word, lower period low word
// - count registers always hold the running count, high and low
// - interrupt on count matching period, 32-bit or each 16-bit
// - converter trigger only from 32-bit pair or the upper timer
// - bit 15 runs or stops the timer, combined or single
// - bit 13 set halts the timer while the chip is idle
// - with bit 1 set, bits 9-8 choose the external count clock
// - with bit 1 clear, count at half oscillator rate
// - bit 6 gates internal-clock counting by the gate pin
// - bits 5-4 select prescale 1, 8, 64 or 256
// - control write while running resets prescale counter
// - unimplemented control bits read as zero
`timescale 1ns/1ps
`default_nettype none
module pair_timer
   import pair_timer_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // chip-level conditions and clock sources
   input  wire logic        chip_idle,
   input  wire logic        gate_in,
   input  wire logic        generic_ext_clk_in,
   input  wire logic        upper_ext_clk_in,
   input  wire logic        low_power_rc_osc,
   input  wire logic        secondary_osc,
   // event outputs
   output logic             low_match_flag,
   output logic             upper_match_flag,
   output logic             adc_trigger
);

   // ******************************
   // state
   // ******************************
   typedef struct packed {
      bus_state_e  bus;
      logic        waitreq;
      logic [31:0] rdata;
      logic [15:0] ctrl;
      logic [15:0] upper_ctrl;
      logic [15:0] count_low_word;
      logic [15:0] count_high_word;
      logic [15:0] period_low_word;
      logic [15:0] period_high_word;
      logic        low_flag;
      logic        high_flag;
      logic        adc_pulse;
      logic        half_phase;
   } state_s;

   state_s st;
   state_s next_st;

   // ******************************
   // pin synchronisers
   // ******************************
   logic gate_lvl;
   logic gen_rise;
   logic upr_rise;
   logic low_power_rc_osc_rise;
   logic secondary_osc_rise;

   // every pin is asynchronous; only agreed rising edges are counted
   pin_sync_edge u_gate (.core_clk(core_clk), .resetn(resetn),
      .pin(gate_in), .level(gate_lvl), .rise());
   pin_sync_edge u_gen (.core_clk(core_clk), .resetn(resetn),
      .pin(generic_ext_clk_in), .level(), .rise(gen_rise));
   pin_sync_edge u_upr (.core_clk(core_clk), .resetn(resetn),
      .pin(upper_ext_clk_in), .level(), .rise(upr_rise));
   pin_sync_edge u_low_power_rc_osc (.core_clk(core_clk), .resetn(resetn),
      .pin(low_power_rc_osc), .level(), .rise(low_power_rc_osc_rise));
   pin_sync_edge u_secondary_osc (.core_clk(core_clk), .resetn(resetn),
      .pin(secondary_osc), .level(), .rise(secondary_osc_rise));

   // ******************************
   // source selection and prescale
   // ******************************
   function automatic logic pick_src(input logic [15:0] c,
                                     input logic half,
                                     input logic gate);
      logic ext;
      ext = 1'b0;
      case (c[ECS_LSB+1:ECS_LSB])
         SRC_GENERIC: ext = gen_rise;
         SRC_LOW_POWER_RC_OSC:    ext = low_power_rc_osc_rise;
         SRC_UPPER:   ext = upr_rise;
         default:     ext = secondary_osc_rise;
      endcase
      if (c[CS_BIT]) begin
         pick_src = ext;
      end else begin
         pick_src = half && (!c[GATE_BIT] || gate);
      end
   endfunction

   function automatic logic runs(input logic [15:0] c);
      runs = c[RUN_BIT] && !(c[IDLE_BIT] && chip_idle);
   endfunction

   logic wide;
   logic ctrl_wr;
   logic upr_wr;
   logic low_src;
   logic upr_src;
   logic low_tick;
   logic upr_tick;

   assign wide = st.ctrl[WIDE_BIT];
   assign ctrl_wr = write && (st.bus == BUS_IDLE)
                    && (address == ADDR_CTRL);
   assign upr_wr = write && (st.bus == BUS_IDLE)
                   && (address == ADDR_STATUS);
   assign low_src = runs(st.ctrl)
                    && pick_src(st.ctrl, st.half_phase, gate_lvl);
   // the whole upper control word is masked off while the pair is joined
   assign upr_src = !wide && runs(st.upper_ctrl)
                    && pick_src(st.upper_ctrl, st.half_phase, gate_lvl);

   // writes to a running control word clear its prescaler
   prescale_div u_low_ps (.core_clk(core_clk), .resetn(resetn),
      .clear(ctrl_wr && st.ctrl[RUN_BIT]),
      .ratio(st.ctrl[PRESC_LSB+1:PRESC_LSB]),
      .tick_in(low_src), .tick_out(low_tick));
   prescale_div u_upr_ps (.core_clk(core_clk), .resetn(resetn),
      .clear(upr_wr && st.upper_ctrl[RUN_BIT]),
      .ratio(st.upper_ctrl[PRESC_LSB+1:PRESC_LSB]),
      .tick_in(upr_src), .tick_out(upr_tick));

   // ******************************
   // next state
   // ******************************
   logic [15:0] wdata16;
   logic        match32;
   logic        match_low;
   logic        match_high;

   assign wdata16 = writedata[15:0];
   // a period of zero matches on every counted tick
   assign match32 = {st.count_high_word, st.count_low_word}
                    == {st.period_high_word, st.period_low_word};
   assign match_low  = st.count_low_word == st.period_low_word;
   assign match_high = st.count_high_word == st.period_high_word;

   // ******************************
   // match events and flag clears
   // ******************************
   logic low_hit;
   logic high_hit;
   logic status_wr;
   logic clr_low;
   logic clr_high;

   // in 32-bit mode only the combined match counts
   assign low_hit   = !wide && low_tick && match_low;
   assign high_hit  = wide ? (low_tick && match32)
                           : (upr_tick && match_high);
   // upper control and flag clears share the status word
   assign status_wr = write && (st.bus == BUS_IDLE)
                      && (address == ADDR_STATUS);
   // write-one-to-clear; a match in the same cycle keeps the flag
   assign clr_low   = status_wr && writedata[ST_LOW_FLAG];
   assign clr_high  = status_wr && writedata[ST_HIGH_FLAG];

   always_comb begin
      next_st = st;
      // internal count clock runs at half the core rate
      next_st.half_phase = !st.half_phase;
      // trigger is a single-cycle pulse; the flags hold until cleared
      next_st.adc_pulse = 1'b0;
      // answer in the cycle after a request is taken, for one cycle only
      next_st.waitreq = !((st.bus == BUS_IDLE) && (read || write));

      // counting
      if (wide) begin
         if (low_tick) begin
            if (match32) begin
               next_st.count_low_word  = COUNT_RESET;
               next_st.count_high_word = COUNT_RESET;
               next_st.high_flag = 1'b1;
               next_st.adc_pulse = 1'b1;
            end else begin
               // carry into the high word on low wrap
               {next_st.count_high_word, next_st.count_low_word} =
                  {st.count_high_word, st.count_low_word} + 32'h1;
            end
         end
      end else begin
         if (low_tick) begin
            if (match_low) begin
               next_st.count_low_word = COUNT_RESET;
               next_st.low_flag = 1'b1;
            end else begin
               next_st.count_low_word = st.count_low_word + 16'h1;
            end
         end
         if (upr_tick) begin
            if (match_high) begin
               next_st.count_high_word = COUNT_RESET;
               next_st.high_flag = 1'b1;
               next_st.adc_pulse = 1'b1;
            end else begin
               next_st.count_high_word = st.count_high_word + 16'h1;
            end
         end
      end

      // bus: answer one cycle after the request is seen
      case (st.bus)
         BUS_IDLE: begin
            if (read || write) begin
               next_st.bus = BUS_ACK;
               next_st.rdata = 32'h0;
               if (read) begin
                  if (address == ADDR_CTRL) begin
                     next_st.rdata = {16'h0, st.ctrl};
                  end else if (address == ADDR_CNT_LOW) begin
                     next_st.rdata = {16'h0, st.count_low_word};
                  end else if (address == ADDR_CNT_HIGH) begin
                     next_st.rdata = {16'h0, st.count_high_word};
                  end else if (address == ADDR_PER_LOW) begin
                     next_st.rdata = {16'h0, st.period_low_word};
                  end else if (address == ADDR_PER_HIGH) begin
                     next_st.rdata = {16'h0, st.period_high_word};
                  end else if (address == ADDR_STATUS) begin
                     next_st.rdata = {st.upper_ctrl, 14'h0,
                                      st.high_flag, st.low_flag};
                  end
               end else begin
                  // a count write beats a tick in the same cycle
                  if (address == ADDR_CTRL) begin
                     next_st.ctrl = wdata16 & CTRL_MASK;
                  end else if (address == ADDR_CNT_LOW) begin
                     next_st.count_low_word = wdata16;
                  end else if (address == ADDR_CNT_HIGH) begin
                     next_st.count_high_word = wdata16;
                  end else if (address == ADDR_PER_LOW) begin
                     next_st.period_low_word = wdata16;
                  end else if (address == ADDR_PER_HIGH) begin
                     next_st.period_high_word = wdata16;
                  end else if (address == ADDR_STATUS) begin
                     next_st.upper_ctrl = writedata[31:16]
                                          & CTRL_MASK & ~(16'h1 << WIDE_BIT);
                     // flag clears are applied below, after the counters
                  end
               end
            end
         end
         default: begin
            next_st.bus = BUS_IDLE;
         end
      endcase

      // set wins over a clear in the same cycle
      next_st.low_flag  = low_hit || (st.low_flag && !clr_low);
      next_st.high_flag = high_hit || (st.high_flag && !clr_high);
   end

   // ******************************
   // registers
   // ******************************
   // every register of the block outside the prescalers and pin synchronisers lives in the one state word
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '{bus: BUS_IDLE, waitreq: 1'b1, rdata: 32'h0,
                 ctrl: CTRL_RESET,
                 upper_ctrl: CTRL_RESET, count_low_word: COUNT_RESET,
                 count_high_word: COUNT_RESET,
                 period_low_word: PERIOD_RESET,
                 period_high_word: PERIOD_RESET, low_flag: 1'b0,
                 high_flag: 1'b0, adc_pulse: 1'b0, half_phase: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign readdata         = st.rdata;
   assign waitrequest      = st.waitreq;
   assign low_match_flag   = st.low_flag;
   assign upper_match_flag = st.high_flag;
   assign adc_trigger      = st.adc_pulse;

endmodule
`default_nettype wire

// file: tb/pair_timer_chk.sv
// port assertions for the pair timer
`timescale 1ns/1ps
`default_nettype none
module pair_timer_chk
   import pair_timer_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        resetn,
   // register bus
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // events
   input wire logic        low_match_flag,
   input wire logic        upper_match_flag,
   input wire logic        adc_trigger
);
   // ***
   // bus and event relations
   // ***
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_take;
      (read || write) && waitrequest;
   endsequence
   sequence s_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   AST_ANSWER: assert property (s_take |=> s_answer)
      else $error("bus answer missing or long");
   AST_RDATA_HOLD: assert property ($changed(readdata) |-> !waitrequest)
      else $error("read data moved outside an answer");
   AST_CTRL_ZERO: assert property (s_take ##0 (read && address == ADDR_CTRL)
      |=> (readdata[15:0] & ~CTRL_MASK) == 16'h0000)
      else $error("unimplemented control bits not zero");
   AST_UNMAPPED: assert property (s_take ##0 (read && address > ADDR_STATUS)
      |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_TRIG_PULSE: assert property (adc_trigger |=> !adc_trigger)
      else $error("trigger longer than one cycle");
   AST_TRIG_FLAG: assert property (adc_trigger |-> ##[0:1] upper_match_flag)
      else $error("trigger without upper flag");
   AST_UFLAG_HOLD: assert property ($fell(upper_match_flag) |->
      $past(write && waitrequest && address == ADDR_STATUS && writedata[1]))
      else $error("upper flag dropped without clear");
   AST_LFLAG_HOLD: assert property ($fell(low_match_flag) |->
      $past(write && waitrequest && address == ADDR_STATUS && writedata[0]))
      else $error("low flag dropped without clear");
endmodule
bind pair_timer pair_timer_chk i_chk (.core_clk(core_clk), .resetn(resetn),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest),
   .low_match_flag(low_match_flag), .upper_match_flag(upper_match_flag),
   .adc_trigger(adc_trigger));
`default_nettype wire

// file: tb/pin_source.sv
// far-side model of the timer clock and gate pins
`timescale 1ns/1ps
`default_nettype none
module pin_source (
   // clock
   input  wire logic core_clk,
   // pins
   output logic [3:0] clk_pins,
   output logic       gate
);
   initial begin
      clk_pins = 4'h0;
      gate     = 1'h0;
   end
   // pins stand low between bursts; 4-cycle phases outlast the syncer
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         repeat (4) @(posedge core_clk);
         clk_pins[idx] <= 1'h1;
         repeat (4) @(posedge core_clk);
         clk_pins[idx] <= 1'h0;
      end
      repeat (6) @(posedge core_clk);
   endtask
   task automatic set_gate(input logic lvl);
      @(posedge core_clk);
      gate <= lvl;
   endtask
endmodule
`default_nettype wire

// file: tb/pair_timer_bench.sv
// self-checking bench for the pair timer
`timescale 1ns/1ps
`default_nettype none
module pair_timer_bench;
   import pair_timer_pkg::*;
   logic        core_clk  = 1'h0;
   logic        resetn    = 1'h0;
   logic [3:0]  address   = 4'h0;
   logic        read      = 1'h0;
   logic        write     = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic        chip_idle = 1'h0;
   logic [31:0] readdata, rv, d, v;
   logic        waitrequest, gate, lo_f, up_f, trig, trig_seen;
   logic [3:0]  pins;
   int          mismatches = 0;
   int          check_count = 0;
   int          seed = 32'h8061;
   int          cyc = 0;
   int          t1;
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   always @(posedge core_clk) if (trig === 1'h1) trig_seen <= 1'h1;
   pair_timer i_dut (.core_clk(core_clk), .resetn(resetn),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .chip_idle(chip_idle), .gate_in(gate),
      .generic_ext_clk_in(pins[3]), .upper_ext_clk_in(pins[1]),
      .low_power_rc_osc(pins[2]), .secondary_osc(pins[0]),
      .low_match_flag(lo_f), .upper_match_flag(up_f), .adc_trigger(trig));
   pin_source i_pins (.core_clk(core_clk), .clk_pins(pins), .gate(gate));
   // ***
   // helpers
   // ***
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] dt);
      address   <= a;
      writedata <= dt;
      read      <= !wr;
      write     <= wr;
      do @(posedge core_clk); while (waitrequest !== 1'h0);
      rv = readdata;
      read  <= 1'h0;
      write <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] dt);
      bus(1'h1, a, dt);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic wait_flag(input logic up, input int lim);
      int n;
      n = 0;
      while ((up ? up_f : lo_f) !== 1'h1 && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      chk(n < lim, 1'h1);
   endtask
   // stopped, zeroed, run for n cycles, stop again; rv ends with count
   task automatic run_span(input logic [31:0] c, input int n);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CNT_LOW, 32'h0);
      wr(ADDR_CTRL, c);
      repeat (n) @(posedge core_clk);
      wr(ADDR_CTRL, 32'h0);
      bus(1'h0, ADDR_CNT_LOW, 32'h0);
   endtask
   function automatic logic span_ok(input int dt, input int p);
      int r[4] = '{1, 8, 64, 256};
      return dt >= 8 * r[p] - 2 && dt <= 8 * r[p] + 2;
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      final_report();
   end
   // ***
   // tests
   // ***
   initial begin
      repeat (4) @(posedge core_clk);
      resetn <= 1'h1;
      @(posedge core_clk);
      rd_chk(ADDR_CTRL, 32'h0);
      rd_chk(ADDR_CNT_HIGH, 32'h0);
      rd_chk(ADDR_PER_HIGH, 32'hFFFF);
      rd_chk(ADDR_STATUS, 32'h0);
      repeat (4) begin
         d = $random(seed) & 32'h7FFF;
         wr(ADDR_CTRL, d);
         rd_chk(ADDR_CTRL, d & CTRL_MASK);
         d = $random(seed);
         wr(ADDR_PER_LOW, d);
         rd_chk(ADDR_PER_LOW, d & 32'hFFFF);
         d = 32'h6 + ({$random(seed)} % 10);
         rd_chk(d[3:0], 32'h0);
      end
      $display("test registers done");
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_CTRL, 32'h0);
         wr(ADDR_CNT_LOW, 32'h0);
         wr(ADDR_PER_LOW, 32'h3);
         wr(ADDR_STATUS, 32'h3);
         trig_seen = 1'h0;
         wr(ADDR_CTRL, 32'h8000 | (p << PRESC_LSB));
         wait_flag(1'h0, 3000);
         t1 = cyc;
         wr(ADDR_STATUS, 32'h1);
         wait_flag(1'h0, 3000);
         chk(span_ok(cyc - t1, p), 1'h1);
         chk(trig_seen | up_f, 1'h0);
      end
      $display("test match and prescale done");
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_STATUS, 32'h3);
      wr(ADDR_PER_HIGH, 32'h2);
      wr(ADDR_CNT_HIGH, 32'h0);
      trig_seen = 1'h0;
      wr(ADDR_STATUS, 32'h8000_0000);
      wait_flag(1'h1, 200);
      repeat (2) @(posedge core_clk);
      chk({trig_seen, lo_f}, 2'h2);
      wr(ADDR_STATUS, 32'h3);
      wr(ADDR_CNT_HIGH, 32'h0);
      wr(ADDR_CNT_LOW, 32'hFFFE);
      wr(ADDR_PER_LOW, 32'h2);
      wr(ADDR_PER_HIGH, 32'h1);
      trig_seen = 1'h0;
      wr(ADDR_CTRL, 32'h8008);
      wait_flag(1'h1, 200);
      repeat (2) @(posedge core_clk);
      chk({trig_seen, lo_f}, 2'h2);
      wr(ADDR_CTRL, 32'h0008);
      rd_chk(ADDR_CNT_HIGH, 32'h0);
      wr(ADDR_STATUS, 32'h8000_0000);
      wr(ADDR_CNT_LOW, 32'hFFFF);
      wr(ADDR_PER_LOW, 32'hFFFF);
      wr(ADDR_PER_HIGH, 32'hFFFF);
      wr(ADDR_CTRL, 32'h8008);
      repeat (8) @(posedge core_clk);
      wr(ADDR_CTRL, 32'h0008);
      rd_chk(ADDR_CNT_HIGH, 32'h1);
      repeat (8) @(posedge core_clk);
      rd_chk(ADDR_CNT_HIGH, 32'h1);
      wr(ADDR_STATUS, 32'h3);
      bus(1'h0, ADDR_CNT_LOW, 32'h0);
      v = rv;
      rd_chk(ADDR_CNT_LOW, v);
      $display("test upper and wide done");
      run_span(32'h8040, 40);
      chk(rv, 32'h0);
      i_pins.set_gate(1'h1);
      run_span(32'h8040, 40);
      chk(rv != 0, 1'h1);
      i_pins.set_gate(1'h0);
      chip_idle <= 1'h1;
      run_span(32'hA000, 40);
      chk(rv, 32'h0);
      run_span(32'h8000, 40);
      chk(rv != 0, 1'h1);
      chip_idle <= 1'h0;
      wr(ADDR_CNT_LOW, 32'h0);
      wr(ADDR_CTRL, 32'h8030);
      repeat (6) begin
         repeat (90) @(posedge core_clk);
         wr(ADDR_CTRL, 32'h8030);
      end
      wr(ADDR_CTRL, 32'h0);
      rd_chk(ADDR_CNT_LOW, 32'h0);
      run_span(32'h8030, 600);
      chk(rv != 0, 1'h1);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTRL, 32'h0);
         wr(ADDR_CNT_LOW, 32'h0);
         wr(ADDR_CTRL, 32'h8042 | (k << ECS_LSB));
         i_pins.pulse((k + 1) % 4, 3);
         i_pins.pulse(k, 5);
         wr(ADDR_CTRL, 32'h0);
         rd_chk(ADDR_CNT_LOW, 32'h5);
      end
      $display("test sources done");
      final_report();
   end
endmodule
`default_nettype wire
